// *** hdl/asr_pkg.sv ***
// Timing constants and types shared by the asynchronous SRAM host controller
package asr_pkg;
   localparam int ASR_ADDR_W  = 18;
   localparam int ASR_DATA_W  = 16;
   localparam int ASR_BE_W    = 2;
   localparam int ASR_CLK_MHZ = 20;
   localparam int ASR_CLK_PS  = 1000000 / ASR_CLK_MHZ;
   // Slow grade figures in ns, so a controller also suits the fast grade
   localparam int ASR_READ_CYCLE_MIN_NS     = 15;
   localparam int ASR_WRITE_CYCLE_MIN_NS    = 15;
   localparam int ASR_ADDRESS_ACCESS_MAX_NS = 15;
   localparam int ASR_SELECT_ACCESS_MAX_NS  = 15;
   localparam int ASR_ADDRESS_SETUP_MIN_NS  = 0;
   localparam int ASR_WRITE_RECOVERY_MIN_NS = 0;
   localparam int ASR_WRITE_PULSE_MIN_NS    = 10;
   localparam int ASR_DATA_SETUP_MIN_NS     = 7;
   localparam int ASR_DATA_HOLD_MIN_NS      = 0;
   localparam int ASR_RELEASE_MAX_NS        = 7;
   // Minimums round up; at least one cycle each
   function automatic int asr_cyc_up(input int ns);
      int c;
      c = (ns * 1000 + ASR_CLK_PS - 1) / ASR_CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int ASR_RD_CYC = asr_cyc_up(ASR_ADDRESS_ACCESS_MAX_NS);
   localparam int ASR_RC_CYC = asr_cyc_up(ASR_READ_CYCLE_MIN_NS);
   localparam int ASR_WP_CYC = asr_cyc_up(ASR_WRITE_PULSE_MIN_NS);
   localparam int ASR_DW_CYC = asr_cyc_up(ASR_DATA_SETUP_MIN_NS);
   localparam int ASR_WC_CYC = asr_cyc_up(ASR_WRITE_CYCLE_MIN_NS);
   localparam int ASR_HZ_CYC = asr_cyc_up(ASR_RELEASE_MAX_NS);
   localparam int ASR_SU_CYC = asr_cyc_up(ASR_ADDRESS_SETUP_MIN_NS);
   localparam int ASR_WR_CYC = asr_cyc_up(ASR_WRITE_RECOVERY_MIN_NS);
   localparam int ASR_DH_CYC = asr_cyc_up(ASR_DATA_HOLD_MIN_NS);
   localparam int ASR_CNT_W   = 4;
   localparam logic [ASR_CNT_W-1:0] ASR_CNT_ZERO = 4'h0;
   typedef enum logic [5:0] {
      ASR_IDLE  = 6'b000001,
      ASR_SETUP = 6'b000010,
      ASR_RDACC = 6'b000100,
      ASR_WRPUL = 6'b001000,
      ASR_HOLD  = 6'b010000,
      ASR_GAP   = 6'b100000
   } asr_state_t;
endpackage

// *** hdl/asr_timer.sv ***
// Down counter that paces each phase of an SRAM access
`timescale 1ns/1ps
module asr_timer (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   // Control
   input  wire logic                          load,
   input  wire logic [asr_pkg::ASR_CNT_W-1:0] load_val,
   // Status
   output logic                               done
);
   import asr_pkg::*;
   logic [ASR_CNT_W-1:0] cnt_r;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_r <= ASR_CNT_ZERO;
      end else if (load) begin
         cnt_r <= load_val;
      end else if (cnt_r != ASR_CNT_ZERO) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end
   // Done ignores load, so a caller may reload on done without a loop
   assign done = (cnt_r == ASR_CNT_ZERO);
endmodule

// *** hdl/asr_host.sv ***
// Host controller that drives a 256K x 16 asynchronous SRAM over its pins
// How it works
// RULE1: Write pulse only with select, enable, byte; code also pulses write enable with select when byte enable is empty
// RULE2: Address changes only while select deasserted
// RULE3: Byte selects fall no earlier than write enable
// RULE4: Host never drives bus during reads
// RULE5: Address settles a cycle before strobes
// RULE6: Address held a cycle after strobes rise
// RULE7: Write enable low at least pulse cycles
// RULE8: Byte selects low whole write pulse
// RULE9: Data driven before pulse, held after; code starts driving as write enable falls if setup is one cycle
// RULE10: Each access lasts at least cycle minimum
// RULE11: Read sampled after address access time
// RULE12: Output enable asserted whole access time
// RULE13: Data sampled before address moves
// RULE14: Turnaround gap before host drives again
// RULE15: Device drive start needs nothing special
// RULE16: Byte enables pick which read bytes count
// RULE17: Nanosecond limits rounded to whole cycles
// RULE18: Bus drivers off before device can drive
`timescale 1ns/1ps
module asr_host (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           reset_n,
   // User request
   input  wire logic                           req_valid,
   output logic                                req_ready,
   input  wire logic                           req_write,
   input  wire logic [asr_pkg::ASR_ADDR_W-1:0] req_addr,
   input  wire logic [asr_pkg::ASR_DATA_W-1:0] req_wdata,
   input  wire logic [asr_pkg::ASR_BE_W-1:0]   req_byte_en,
   // User answer
   output logic                                rsp_valid,
   output logic [asr_pkg::ASR_DATA_W-1:0]      rsp_rdata,
   // SRAM pins
   output logic [asr_pkg::ASR_ADDR_W-1:0]      word_address,
   output logic                                chip_select_n,
   output logic                                output_enable_n,
   output logic                                write_enable_n,
   output logic                                lower_byte_select_n,
   output logic                                upper_byte_select_n,
   input  wire logic [asr_pkg::ASR_DATA_W-1:0] data_bus_in,
   output logic [asr_pkg::ASR_DATA_W-1:0]      data_bus_out,
   output logic                                data_bus_oe
);
   import asr_pkg::*;

   // Timer loads one less than the cycles a phase must last
   function automatic logic [ASR_CNT_W-1:0] asr_cnt(input int cyc);
      return ASR_CNT_W'(cyc - 1); //RULE17
   endfunction

   function automatic int asr_max(input int a, input int b);
      return (a > b) ? a : b;
   endfunction

   // Strobes are low only in the two access states
   function automatic logic asr_strobing(input asr_state_t s);
      return (s == ASR_RDACC) || (s == ASR_WRPUL);
   endfunction

   // Each phase covers every limit that ends inside it; one counter width fits all
   localparam int RD_LEN = asr_max(asr_max(ASR_RD_CYC, ASR_RC_CYC),
                                   asr_cyc_up(ASR_SELECT_ACCESS_MAX_NS)); //RULE17
   localparam int WP_LEN = asr_max(asr_max(ASR_WP_CYC, ASR_DW_CYC), ASR_WC_CYC);
   localparam int HD_LEN = asr_max(ASR_WR_CYC, ASR_DH_CYC);

   asr_state_t           state_r;
   asr_state_t           state_nxt;
   logic                 wr_r;
   logic                 was_read_r;
   logic [ASR_BE_W-1:0]  be_r;
   logic                 tmr_load;
   logic [ASR_CNT_W-1:0] tmr_val;
   logic                 tmr_done;
   logic                 take;
   logic                 strobe_nxt;

   asr_timer u_timer (
      .clk      (clk),
      .reset_n  (reset_n),
      .load     (tmr_load),
      .load_val (tmr_val),
      .done     (tmr_done)
   );

   // Empty byte enable is accepted and runs a full access with both byte selects high
   assign req_ready = (state_r == ASR_IDLE);
   assign take      = req_valid && req_ready;
   // Strobes follow the next state, so each leaves a flop with no glitch
   assign strobe_nxt = asr_strobing(state_nxt);

   always_comb begin
      state_nxt = state_r;
      tmr_load  = 1'b0;
      tmr_val   = ASR_CNT_ZERO;
      case (state_r)
         ASR_IDLE: begin
            if (take) begin
               state_nxt = ASR_SETUP;
               tmr_load  = 1'b1;
               // After a read, the device may still drive for the release time
               tmr_val   = (req_write && was_read_r) ? asr_cnt(ASR_HZ_CYC) //RULE18
                                                     : asr_cnt(ASR_SU_CYC); //RULE5
            end
         end
         ASR_SETUP: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               if (wr_r) begin
                  state_nxt = ASR_WRPUL;
                  tmr_val   = asr_cnt(WP_LEN); //RULE7 RULE9
               end else begin
                  state_nxt = ASR_RDACC;
                  tmr_val   = asr_cnt(RD_LEN); //RULE11 RULE18
               end
            end
         end
         ASR_RDACC: begin
            if (tmr_done) begin
               state_nxt = ASR_GAP;
               tmr_load  = 1'b1;
               tmr_val   = asr_cnt(ASR_HZ_CYC); //RULE14
            end
         end
         ASR_WRPUL: begin
            if (tmr_done) begin
               state_nxt = ASR_HOLD;
               tmr_load  = 1'b1;
               tmr_val   = asr_cnt(HD_LEN); //RULE6
            end
         end
         ASR_HOLD: begin
            if (tmr_done) begin
               state_nxt = ASR_IDLE;
            end
         end
         ASR_GAP: begin
            if (tmr_done) begin
               state_nxt = ASR_IDLE;
            end
         end
         default: begin
            state_nxt = ASR_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= ASR_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Request capture; address moves only in idle with all strobes high
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         word_address <= '0;
         data_bus_out <= '0;
         wr_r         <= 1'b0;
         be_r         <= 2'h0;
         was_read_r   <= 1'b0;
      end else if (take) begin
         word_address <= req_addr; //RULE2
         data_bus_out <= req_wdata;
         wr_r         <= req_write;
         be_r         <= req_byte_en;
         was_read_r   <= !req_write;
      end
   end

   // Strobes registered; a read and a write each span at least the cycle minimum
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chip_select_n       <= 1'b1;
         output_enable_n     <= 1'b1;
         write_enable_n      <= 1'b1;
         lower_byte_select_n <= 1'b1;
         upper_byte_select_n <= 1'b1;
      end else begin
         // On a write, select and write enable fall together, so the device never drives during a write
         chip_select_n       <= !strobe_nxt; //RULE10
         output_enable_n     <= !(state_nxt == ASR_RDACC); //RULE12
         write_enable_n      <= !(state_nxt == ASR_WRPUL); //RULE1 RULE3
         lower_byte_select_n <= !(strobe_nxt && be_r[0]); //RULE8
         upper_byte_select_n <= !(strobe_nxt && be_r[1]); //RULE8
      end
   end

   // Drive data from the second setup cycle, else from the pulse, through hold of a write only
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         data_bus_oe <= 1'b0;
      end else begin
         // Third term matters only when setup runs longer than one cycle
         data_bus_oe <= wr_r && (state_nxt == ASR_WRPUL ||
                        (state_nxt == ASR_HOLD) ||
                        (state_nxt == ASR_SETUP && state_r == ASR_SETUP)); //RULE4 RULE9
      end
   end

   // Sample in the last access cycle while address is still stable
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= 1'b0;
         if (state_r == ASR_RDACC && tmr_done) begin
            rsp_valid <= 1'b1; //RULE13
            // Unselected lanes read as zero, whatever floats on them
            rsp_rdata <= {be_r[1] ? data_bus_in[15:8] : 8'h00,
                          be_r[0] ? data_bus_in[7:0]  : 8'h00}; //RULE16
         end else if (state_r == ASR_HOLD && tmr_done) begin
            // Write done; read data keeps its last value
            rsp_valid <= 1'b1;
         end
      end
   end
endmodule

// *** dv/asr_host_asserts.sv ***
// Pin timing checker for the SRAM host controller
`timescale 1ns/1ps
module asr_host_asserts (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // Answer
   input wire logic        rsp_valid,
   input wire logic [15:0] rsp_rdata,
   // Pins
   input wire logic [17:0] word_address,
   input wire logic        chip_select_n,
   input wire logic        output_enable_n,
   input wire logic        write_enable_n,
   input wire logic        lower_byte_select_n,
   input wire logic        upper_byte_select_n,
   input wire logic [15:0] data_bus_in,
   input wire logic [15:0] data_bus_out,
   input wire logic        data_bus_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_we_qual;
      !write_enable_n |-> !chip_select_n && output_enable_n && data_bus_oe;
   endproperty
   a_we_qual: assert property (p_we_qual) else $error("write strobe unqualified");
   property p_addr;
      !$stable(word_address) |-> chip_select_n && $past(chip_select_n);
   endproperty
   a_addr: assert property (p_addr) else $error("address moved while selected");
   property p_clash;
      !output_enable_n |-> !data_bus_oe;
   endproperty
   a_clash: assert property (p_clash) else $error("host drives during read");
   property p_we_pulse;
      $fell(write_enable_n) |-> $fell(chip_select_n) ##1
         write_enable_n && chip_select_n && lower_byte_select_n && upper_byte_select_n;
   endproperty
   a_we_pulse: assert property (p_we_pulse) else $error("write pulse shape");
   property p_wdata;
      !write_enable_n |-> $stable(data_bus_out) ##1 data_bus_oe && $stable(data_bus_out);
   endproperty
   a_wdata: assert property (p_wdata) else $error("write data not held");
   property p_read;
      $fell(output_enable_n) |=> output_enable_n && rsp_valid;
   endproperty
   a_read: assert property (p_read) else $error("read answer timing");
   property p_rdata;
      rsp_valid && !$past(output_enable_n) |-> rsp_rdata ==
         {$past(upper_byte_select_n) ? 8'h00 : $past(data_bus_in[15:8]),
          $past(lower_byte_select_n) ? 8'h00 : $past(data_bus_in[7:0])};
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data lanes");
   property p_turn;
      $rose(output_enable_n) |-> !data_bus_oe [*2];
   endproperty
   a_turn: assert property (p_turn) else $error("no turnaround gap");
   c_write: cover property ($fell(write_enable_n));
   c_read: cover property (rsp_valid && !$past(output_enable_n));
   c_part: cover property ($fell(output_enable_n) && lower_byte_select_n != upper_byte_select_n);
endmodule
bind asr_host asr_host_asserts chk_u (.clk, .reset_n, .rsp_valid, .rsp_rdata, .word_address,
   .chip_select_n, .output_enable_n, .write_enable_n, .lower_byte_select_n,
   .upper_byte_select_n, .data_bus_in, .data_bus_out, .data_bus_oe);

// *** dv/asr_sram_model.sv ***
// Behavioural model of the 256K x 16 asynchronous SRAM
`timescale 1ns/1ps
module asr_sram_model (
   // Clock, for write capture and the floating-lane pattern
   input  wire logic        clk,
   // Pins
   input  wire logic [17:0] word_address,
   input  wire logic        chip_select_n,
   input  wire logic        output_enable_n,
   input  wire logic        write_enable_n,
   input  wire logic        lower_byte_select_n,
   input  wire logic        upper_byte_select_n,
   input  wire logic [15:0] data_bus,
   output logic      [15:0] dev_q
);
   logic [15:0] mem_r [0:262143];
   logic [15:0] noise_r = 16'hA5C3;
   logic        rd_en;
   // Floating lanes change every cycle so a stale value never passes
   always @(posedge clk) noise_r <= ~noise_r ^ 16'h0101;
   always @(posedge clk) begin
      if (!chip_select_n && !write_enable_n) begin
         if (!lower_byte_select_n) mem_r[word_address][7:0] <= data_bus[7:0];
         if (!upper_byte_select_n) mem_r[word_address][15:8] <= data_bus[15:8];
      end
   end
   assign rd_en = !chip_select_n && !output_enable_n && write_enable_n;
   assign dev_q[7:0] = (rd_en && !lower_byte_select_n) ? mem_r[word_address][7:0] :
                       noise_r[7:0];
   assign dev_q[15:8] = (rd_en && !upper_byte_select_n) ? mem_r[word_address][15:8] :
                        noise_r[15:8];
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
module tb;
   import asr_pkg::*;
   logic        clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
   logic [17:0] req_addr = 18'h00000, word_address;
   logic [15:0] req_wdata = 16'h0000, rsp_rdata, data_bus_in, data_bus_out, dev_q;
   logic [1:0]  req_byte_en = 2'h0;
   logic        req_ready, rsp_valid, chip_select_n, output_enable_n, write_enable_n;
   logic        lower_byte_select_n, upper_byte_select_n, data_bus_oe;
   logic [31:0] rnd = 32'h0000004E;
   logic [17:0] addr_t [0:7];
   logic [15:0] shadow [0:7];
   logic [16:0] exp_q [$];
   logic [16:0] cur;
   int          err_count = 0, n_tests = 0, i;
   assign data_bus_in = data_bus_oe ? data_bus_out : dev_q;
   asr_host dut_u (.clk, .reset_n, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
      .req_byte_en, .rsp_valid, .rsp_rdata, .word_address, .chip_select_n, .output_enable_n,
      .write_enable_n, .lower_byte_select_n, .upper_byte_select_n, .data_bus_in,
      .data_bus_out, .data_bus_oe);
   asr_sram_model mem_u (.clk, .word_address, .chip_select_n, .output_enable_n,
      .write_enable_n, .lower_byte_select_n, .upper_byte_select_n, .data_bus(data_bus_in),
      .dev_q);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task give_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string name, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask
   // Expectation is noted before the request goes out
   task automatic op(input logic w, input int k, input logic [15:0] d, input logic [1:0] be);
      int n;
      @(negedge clk);
      req_valid = 1'b1;
      req_write = w;
      req_addr = addr_t[k];
      req_wdata = d;
      req_byte_en = be;
      if (w && be[0]) shadow[k][7:0] = d[7:0];
      if (w && be[1]) shadow[k][15:8] = d[15:8];
      exp_q.push_back({!w, shadow[k] & {{8{be[1]}}, {8{be[0]}}}});
      for (n = 0; n < 20 && req_ready !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
   endtask
   always @(posedge clk) begin
      if (reset_n && rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("rsp_valid", 16'h0000, 16'h0001);
         else begin
            cur = exp_q.pop_front();
            if (cur[16]) chk("rsp_rdata", cur[15:0], rsp_rdata);
         end
      end
   end
   initial forever #25 clk = ~clk;
   initial begin
      repeat (4000) @(posedge clk);
      err_count++;
      give_verdict();
   end
   initial begin
      // Edge words of the address space plus random ones
      for (i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         addr_t[i] = {i[2:0], (i == 7) ? 15'h7FFF : (i == 0) ? 15'h0000 : rnd[14:0]};
      end
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      for (i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         op(1'b1, i, rnd[15:0], 2'h3);
      end
      for (i = 0; i < 48; i++) begin
         rnd = xs(rnd);
         op(rnd[20], int'(rnd[18:16]), rnd[15:0], rnd[23:22]);
      end
      repeat (10) @(negedge clk);
      chk("pending", 16'h0000, 16'(exp_q.size()));
      give_verdict();
   end
endmodule
